/* File: hdl/gpc_cfg.svh */
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// Register indices; byte address is four times the index
`define GPC_IDX_PME       10'h03D
`define GPC_IDX_GUARD     10'h03E
`define GPC_IDX_RING      10'h03F
`define GPC_IDX_STATUS    10'h030
`define GPC_IDX_MASK      10'h031
`define GPC_IDX_DATA      10'h032

// Reset values
`define GPC_CFG_RST       8'h01
`define GPC_ZERO_RST      8'h00

// Field positions
`define GPC_BIT_DIR       0
`define GPC_BIT_POL       1
`define GPC_BIT_ALT1      2
`define GPC_ALT_HI        3
`define GPC_ALT_LO        2
`define GPC_BIT_OD        7
`define GPC_BIT_EDGE_EV   0

// Writable bits; reserved bits read as zero
`define GPC_WMASK_PME     8'h87
`define GPC_WMASK_ALT2    8'h8F
`define GPC_WMASK_EVT     8'h01
`define GPC_WMASK_DATA    8'h07

`endif

/* File: hdl/gpc_pkg.sv */
package gpc_pkg;

  // Two-bit alternate function codes of the second pin
  typedef enum logic [1:0] {
    GPC_ALT_GPIO  = 2'h0,
    GPC_ALT_GUARD = 2'h1,
    GPC_ALT_RSVD  = 2'h2,
    GPC_ALT_EDGE  = 2'h3
  } gpc_alt_t;

  // Third pin alternate codes
  typedef enum logic [1:0] {
    GPC_RI_GPIO  = 2'h0,
    GPC_RI_RING  = 2'h1,
    GPC_RI_RSV2  = 2'h2,
    GPC_RI_RSV3  = 2'h3
  } gpc_ri_alt_t;

endpackage

/* File: hdl/gpc_top.sv */
`timescale 1ns/1ps
`include "gpc_cfg.svh"

module gpc_top
  import gpc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        main_reset_n,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [2:0]  pin_i,
  output logic [2:0]       pin_o,
  output logic [2:0]       pin_oe,
  input  wire logic        power_event_req,
  output logic             second_port_ring_indicator_n,
  output logic             disable_reg_write_control,
  output logic             edge_irq_event,
  output logic             irq
);

  logic [7:0]  cfg_ff [3];
  logic [7:0]  nxt_cfg [3];
  logic [7:0]  status_ff;
  logic [7:0]  nxt_status;
  logic [7:0]  mask_ff;
  logic [2:0]  out_data_ff;
  logic        wr_pend_ff;
  logic [9:0]  wr_idx_ff;
  logic [31:0] hrdata_ff;
  logic        prev_lvl_ff;
  logic        edge_ev_ff;

  // Bus decode
  wire         addr_ok  = hsel & hready & htrans[1];
  wire         rd_req   = addr_ok & ~hwrite;
  wire [9:0]   rd_idx   = haddr[11:2];
  wire [7:0]   wdata    = hwdata[7:0];
  wire         wr_pme   = wr_pend_ff & (wr_idx_ff == `GPC_IDX_PME);
  wire         wr_guard = wr_pend_ff & (wr_idx_ff == `GPC_IDX_GUARD);
  wire         wr_ring  = wr_pend_ff & (wr_idx_ff == `GPC_IDX_RING);
  wire         wr_stat  = wr_pend_ff & (wr_idx_ff == `GPC_IDX_STATUS);
  wire         wr_mask  = wr_pend_ff & (wr_idx_ff == `GPC_IDX_MASK);
  wire         wr_data  = wr_pend_ff & (wr_idx_ff == `GPC_IDX_DATA);

  // Function selection per pin
  wire         pme_sel   = cfg_ff[0][`GPC_BIT_ALT1];
  gpc_alt_t    guard_alt;
  gpc_ri_alt_t ring_alt;
  assign guard_alt = gpc_alt_t'(cfg_ff[1][`GPC_ALT_HI:`GPC_ALT_LO]);
  assign ring_alt  = gpc_ri_alt_t'(cfg_ff[2][`GPC_ALT_HI:`GPC_ALT_LO]);
  wire         guard_sel = (guard_alt == GPC_ALT_GUARD);
  wire         edge_sel  = (guard_alt == GPC_ALT_EDGE);
  wire         ring_sel  = (ring_alt == GPC_RI_RING);

  // Effective direction and polarity; write guard overrides the register
  wire [2:0]   dir_in;
  wire [2:0]   pol;
  assign dir_in = {cfg_ff[2][`GPC_BIT_DIR],
                   guard_sel | cfg_ff[1][`GPC_BIT_DIR],
                   cfg_ff[0][`GPC_BIT_DIR]};
  assign pol    = {cfg_ff[2][`GPC_BIT_POL],
                   ~guard_sel & cfg_ff[1][`GPC_BIT_POL],
                   cfg_ff[0][`GPC_BIT_POL]};

  // Internal levels seen through the polarity stage
  wire [2:0]   lvl = pin_i ^ pol;

  // Value presented toward each pad; the event request is active high inside
  wire         power_event_out_n = ~power_event_req;
  wire [2:0]   pad_val;
  assign pad_val = {out_data_ff[2] ^ pol[2],
                    out_data_ff[1] ^ pol[1],
                    (pme_sel ? power_event_out_n : out_data_ff[0]) ^ pol[0]};

  // Pad drivers; open-drain only ever pulls low, so the data bit is zero
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pad
      wire od = cfg_ff[gi][`GPC_BIT_OD];
      assign pin_o[gi]  = od ? 1'b0 : pad_val[gi];
      assign pin_oe[gi] = ~dir_in[gi] & (od ? ~pad_val[gi] : 1'b1);
    end
  endgenerate

  // Alternate inputs; inactive high when not routed
  assign second_port_ring_indicator_n = ring_sel ? lvl[2] : 1'b1;
  // High grants writes to the disable register
  assign disable_reg_write_control = ~guard_sel | ~pin_i[1];

  // Config writes: masked, locked field kept, main reset clears the field
  always_comb
  begin
    nxt_cfg[0] = cfg_ff[0];
    nxt_cfg[1] = cfg_ff[1];
    nxt_cfg[2] = cfg_ff[2];
    if (wr_pme)
      nxt_cfg[0] = wdata & `GPC_WMASK_PME;
    if (wr_guard)
    begin
      nxt_cfg[1] = wdata & `GPC_WMASK_ALT2;
      if (guard_sel)
        nxt_cfg[1][`GPC_ALT_HI:`GPC_ALT_LO] = GPC_ALT_GUARD;
    end
    if (wr_ring)
      nxt_cfg[2] = wdata & `GPC_WMASK_ALT2;
    if (!main_reset_n)
      nxt_cfg[1][`GPC_ALT_HI:`GPC_ALT_LO] = GPC_ALT_GPIO;
  end

  // Sticky status: a fresh edge wins over a simultaneous write-one clear
  always_comb
  begin
    nxt_status = status_ff;
    if (wr_stat)
      nxt_status = status_ff & ~(wdata & `GPC_WMASK_EVT);
    if (edge_ev_ff)
      nxt_status[`GPC_BIT_EDGE_EV] = 1'b1;
  end

  // Level interrupt, high while any unmasked sticky bit is set
  assign irq = |(status_ff & mask_ff);

  // Config and status registers; standby reset is the asynchronous one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_ff[0] <= `GPC_CFG_RST;
      cfg_ff[1] <= `GPC_CFG_RST;
      cfg_ff[2] <= `GPC_CFG_RST;
      status_ff <= `GPC_ZERO_RST;
    end
    else
    begin
      cfg_ff[0] <= nxt_cfg[0];
      cfg_ff[1] <= nxt_cfg[1];
      cfg_ff[2] <= nxt_cfg[2];
      status_ff <= nxt_status;
    end
  end

  // Mask and output data registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_ff     <= `GPC_ZERO_RST;
      out_data_ff <= 3'h0;
    end
    else
    begin
      if (wr_mask)
        mask_ff <= wdata & `GPC_WMASK_EVT;
      if (wr_data)
        out_data_ff <= wdata[2:0];
    end
  end

  // Both-edge detector; tracks always so entering the mode is glitch-free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_lvl_ff <= 1'b1; // Idle level of the pulled-up pin, no false edge
      edge_ev_ff  <= 1'b0;
    end
    else
    begin
      prev_lvl_ff <= lvl[1];
      edge_ev_ff  <= edge_sel & (lvl[1] ^ prev_lvl_ff);
    end
  end

  assign edge_irq_event = edge_ev_ff;

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_byte =
    (rd_idx == `GPC_IDX_PME)    ? cfg_ff[0] :
    (rd_idx == `GPC_IDX_GUARD)  ? cfg_ff[1] :
    (rd_idx == `GPC_IDX_RING)   ? cfg_ff[2] :
    (rd_idx == `GPC_IDX_STATUS) ? status_ff :
    (rd_idx == `GPC_IDX_MASK)   ? mask_ff   :
    (rd_idx == `GPC_IDX_DATA)   ? {5'h00, lvl} : 8'h00;

  // Bus pipeline: capture address phase, act in data phase, zero wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 10'h000;
      hrdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      if (hready)
      begin
        wr_pend_ff <= addr_ok & hwrite;
        wr_idx_ff  <= rd_idx;
      end
      if (rd_req)
        hrdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // Checks
  AST_DIR_IN: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff[0][`GPC_BIT_DIR] |-> !pin_oe[0])
    else $error("input pin is driven");

  AST_POL_RING: assert property (@(posedge hclk) disable iff (!hresetn)
    ring_sel |-> second_port_ring_indicator_n == (pin_i[2] ^ cfg_ff[2][`GPC_BIT_POL]))
    else $error("ring indicator polarity wrong");

  AST_OD_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff[2][`GPC_BIT_OD] |-> !pin_o[2])
    else $error("open drain pin drives high");

  AST_PME_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (pme_sel && cfg_ff[0][1:0] == 2'h0 && !cfg_ff[0][`GPC_BIT_OD])
      |-> pin_oe[0] && pin_o[0] == !power_event_req)
    else $error("power event not active low");

  AST_PME_OD: assert property (@(posedge hclk) disable iff (!hresetn)
    (pme_sel && cfg_ff[0][1:0] == 2'h0 && cfg_ff[0][`GPC_BIT_OD])
      |-> pin_oe[0] == power_event_req)
    else $error("open drain power event wrong");

  AST_GUARD_IN: assert property (@(posedge hclk) disable iff (!hresetn)
    guard_sel |-> !pin_oe[1] && disable_reg_write_control == !pin_i[1])
    else $error("guard pin not plain input");

  AST_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (guard_sel && main_reset_n) |=> guard_sel)
    else $error("locked field changed");

  AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    !main_reset_n |=> guard_alt == GPC_ALT_GPIO)
    else $error("main reset did not clear field");

  AST_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    (guard_sel && pin_i[1]) |-> !disable_reg_write_control)
    else $error("disable register writable while pin high");

  AST_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
    (edge_sel && (lvl[1] != prev_lvl_ff)) |=> edge_irq_event ##1 status_ff[0])
    else $error("edge not raised as event");

  AST_NO_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
    !edge_sel |=> !edge_irq_event)
    else $error("event outside edge mode");

  // Driver and polarity checks on the first two pins, with and without the power event routed
  AST_DIR_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cfg_ff[0][`GPC_BIT_DIR] && !cfg_ff[0][`GPC_BIT_OD]) |-> pin_oe[0])
    else $error("output pin not driven");

  AST_POL_DATA: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pme_sel && !cfg_ff[0][`GPC_BIT_DIR] && !cfg_ff[0][`GPC_BIT_OD])
      |-> pin_o[0] == (out_data_ff[0] ^ cfg_ff[0][`GPC_BIT_POL]))
    else $error("output polarity wrong");

  AST_PP_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    (!guard_sel && !cfg_ff[1][`GPC_BIT_DIR] && !cfg_ff[1][`GPC_BIT_OD])
      |-> pin_oe[1] && pin_o[1] == (out_data_ff[1] ^ cfg_ff[1][`GPC_BIT_POL]))
    else $error("push-pull pin wrong");

  AST_PME_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
    (pme_sel && !cfg_ff[0][`GPC_BIT_DIR] && !cfg_ff[0][`GPC_BIT_OD])
      |-> pin_o[0] == (!power_event_req ^ cfg_ff[0][`GPC_BIT_POL]))
    else $error("power event not routed to pin");

  AST_PME_PP: assert property (@(posedge hclk) disable iff (!hresetn)
    (pme_sel && !cfg_ff[0][`GPC_BIT_DIR] && !cfg_ff[0][`GPC_BIT_OD]) |-> pin_oe[0])
    else $error("push-pull power event not driven");

  // Alternate function checks
  AST_RSVD_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    (guard_alt == GPC_ALT_RSVD) |=> !edge_irq_event)
    else $error("event in reserved mode");

  AST_GUARD_POL: assert property (@(posedge hclk) disable iff (!hresetn)
    guard_sel |-> dir_in[1] && !pol[1])
    else $error("guard pin not forced to plain input");

  AST_LOCK_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_guard && guard_sel && main_reset_n) |=> guard_alt == GPC_ALT_GUARD)
    else $error("write changed locked field");

  AST_FREE_RW: assert property (@(posedge hclk) disable iff (!hresetn)
    !guard_sel |-> disable_reg_write_control)
    else $error("disable register locked without guard");

  AST_GUARD_RW: assert property (@(posedge hclk) disable iff (!hresetn)
    (guard_sel && !pin_i[1]) |-> disable_reg_write_control)
    else $error("disable register locked while pin low");

  AST_RING_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
    !ring_sel |-> second_port_ring_indicator_n)
    else $error("ring indicator active while not routed");

  // Event path checks
  AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    (status_ff[`GPC_BIT_EDGE_EV] && !wr_stat) |=> status_ff[`GPC_BIT_EDGE_EV])
    else $error("status bit lost without a clear");

  AST_IRQ_LVL: assert property (@(posedge hclk) disable iff (!hresetn)
    (status_ff[`GPC_BIT_EDGE_EV] && mask_ff[`GPC_BIT_EDGE_EV]) |-> irq)
    else $error("unmasked event without interrupt");

  COV_LOCK:  cover property (@(posedge hclk) disable iff (!hresetn)
    !guard_sel ##1 guard_sel);
  COV_EDGE:  cover property (@(posedge hclk) disable iff (!hresetn)
    edge_irq_event ##1 irq);
  COV_PME:   cover property (@(posedge hclk) disable iff (!hresetn)
    pme_sel && pin_oe[0]);
  COV_CLR:   cover property (@(posedge hclk) disable iff (!hresetn)
    wr_stat && edge_ev_ff);
  COV_RING:  cover property (@(posedge hclk) disable iff (!hresetn)
    ring_sel && !second_port_ring_indicator_n);

endmodule

/* File: dv/gpc_board.sv */
`timescale 1ns/1ps
// Board side of the three pins: pull-ups hold any line that nobody drives
module gpc_board
(
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] drv_en,
  input  wire logic [2:0] drv_val,
  output logic      [2:0] pin_lvl
);
  // The chip's driver wins; a released open-drain line floats high
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pin_lvl[i] = pin_oe[i] ? pin_o[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
endmodule

/* File: dv/gpio_pin_function_config_tb.sv */
`timescale 1ns/1ps
module gpio_pin_function_config_tb;
  import gpc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        main_reset_n = 1'b1;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        pme_req = 1'b0;
  logic [2:0]  drv_en = 3'h0;
  logic [2:0]  drv_val = 3'h0;
  logic        hreadyout, hresp, ring_n, wr_ctl, edge_ev, irq;
  logic [31:0] hrdata, rd;
  logic [2:0]  pin_o, pin_oe, pin_i;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n_edge = 0;
  int          base;

  always #50 hclk = ~hclk;
  // Pulses are counted so that a lost or doubled edge event shows up
  always @(posedge hclk) if (edge_ev === 1'b1) n_edge++;

  gpc_top u_dut (.hclk(hclk), .hresetn(hresetn), .main_reset_n(main_reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .power_event_req(pme_req),
    .second_port_ring_indicator_n(ring_n), .disable_reg_write_control(wr_ctl),
    .edge_irq_event(edge_ev), .irq(irq));
  gpc_board u_board (.pin_o(pin_o), .pin_oe(pin_oe), .drv_en(drv_en), .drv_val(drv_val),
    .pin_lvl(pin_i));

  task wrap_up();
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; read data is taken at the data phase's end edge
  task xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(rd, e);
  endtask

  // Give the pins a few cycles so any edge event reaches the status bit
  task board(input logic [2:0] en, input logic [2:0] v);
    @(posedge hclk);
    drv_en <= en;
    drv_val <= v;
    repeat (6) @(posedge hclk);
    #1;
  endtask

  task pme(input logic v);
    @(posedge hclk);
    pme_req <= v;
    #1;
  endtask

  task t_reset();
    rchk(12'hF4, 32'h01);
    rchk(12'hF8, 32'h01);
    rchk(12'hFC, 32'h01);
    rchk(12'hC0, 32'h00);
    rchk(12'h000, 32'h00);
    chk(pin_oe, 3'h0);
  endtask

  task t_drive();
    xfer(12'hC8, 1'b1, 8'h01);
    xfer(12'hF4, 1'b1, 8'h00);
    chk({pin_oe[0], pin_o[0]}, 2'b11);
    xfer(12'hF4, 1'b1, 8'h02);
    chk(pin_o[0], 1'b0);
    xfer(12'hF4, 1'b1, 8'h82);
    chk({pin_oe[0], pin_o[0]}, 2'b10);
    xfer(12'hF4, 1'b1, 8'h80);
    chk(pin_oe[0], 1'b0);
    xfer(12'hF4, 1'b1, 8'hFF);
    rchk(12'hF4, 32'h87);
    xfer(12'hF4, 1'b1, 8'h03);
    board(3'h1, 3'h1);
    rchk(12'hC8, 32'h06);
  endtask

  task t_pme();
    xfer(12'hF4, 1'b1, 8'h04);
    pme(1'b1);
    chk({pin_oe[0], pin_o[0]}, 2'b10);
    pme(1'b0);
    chk({pin_oe[0], pin_o[0]}, 2'b11);
    xfer(12'hF4, 1'b1, 8'h84);
    pme(1'b1);
    chk({pin_oe[0], pin_o[0]}, 2'b10);
    pme(1'b0);
    chk(pin_oe[0], 1'b0);
  endtask

  task t_guard();
    xfer(12'hF8, 1'b1, 8'h06);
    board(3'h2, 3'h2);
    chk(pin_oe[1], 1'b0);
    chk(wr_ctl, 1'b0);
    xfer(12'hC8, 1'b0, 8'h00);
    chk(rd[1], 1'b1);
    board(3'h2, 3'h0);
    chk(wr_ctl, 1'b1);
    xfer(12'hF8, 1'b1, 8'h0C);
    xfer(12'hF8, 1'b0, 8'h00);
    chk(rd[3:2], 2'h1);
    @(posedge hclk);
    main_reset_n <= 1'b0;
    @(posedge hclk);
    main_reset_n <= 1'b1;
    xfer(12'hF8, 1'b0, 8'h00);
    chk(rd[3:2], 2'h0);
  endtask

  task t_edge();
    base = n_edge;
    xfer(12'hC4, 1'b1, 8'h01);
    xfer(12'hF8, 1'b1, 8'h0D);
    board(3'h2, 3'h2);
    chk(n_edge - base, 1);
    chk(irq, 1'b1);
    xfer(12'hC0, 1'b1, 8'h01);
    chk(irq, 1'b0);
    board(3'h2, 3'h0);
    chk(n_edge - base, 2);
    xfer(12'hC4, 1'b1, 8'h00);
    chk(irq, 1'b0);
    rchk(12'hC0, 32'h01);
    xfer(12'hC0, 1'b1, 8'h01);
    xfer(12'hF8, 1'b1, 8'h01);
    board(3'h2, 3'h2);
    chk(n_edge - base, 2);
    xfer(12'hF8, 1'b1, 8'h09);
    board(3'h2, 3'h0);
    chk(n_edge - base, 2);
  endtask

  task t_ring();
    for (int c = 0; c < 4; c++)
    begin
      xfer(12'hFC, 1'b1, {4'h0, c[1:0], 2'b01});
      board(3'h4, 3'h0);
      chk(ring_n, (c == 1) ? 1'b0 : 1'b1);
      board(3'h4, 3'h4);
      chk(ring_n, 1'b1);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_drive();
    t_pme();
    t_guard();
    t_edge();
    t_ring();
    wrap_up();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
